// ===== rtl/ddrcm_pkg.sv
// Constants and types for the DDR2 command and mode block.
// Assumes pins are sampled on rising sys_clk.
package ddrcm_pkg;

    // ==========================================================
    // Command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MODE = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // ==========================================================
    // Address roles and mode fields
    localparam int AP_BIT = 10;
    localparam int MODE_W = 13;
    localparam int LEN_MSB = 2;
    localparam int BT_BIT = 3;
    localparam int DLLRST_BIT = 8;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] LAST4 = 3'h3;
    localparam logic [2:0] LAST8 = 3'h7;

    // ==========================================================
    // Register map and bus answers
    localparam int AXI_ADDR_W = 8;
    localparam int PL_W = 3;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_REFROW = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Burst engine states
    typedef enum logic [1:0] {BST_IDLE, BST_READ, BST_WRITE} ddrcm_burst_type;

endpackage : ddrcm_pkg

// ===== rtl/ddrcm_top.sv
// DDR2 command decode, bank state, burst engine and mode registers.
// Assumes the controller keeps tMRD and tRP itself and that
// pins are synchronous to sys_clk.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// - NO_OPERATION_COMMAND registers nothing, work continues
// - Bank pins pick mode register, address holds data
// - Activate opens row until bank precharged
// - Read bursts from column, A10 auto precharge
// - Write bursts from column, optional auto precharge
// - Posted latency delays column command registration
// - Mask low stores lane, high keeps location
// - Precharge closes one bank or all
// - Idle bank needs activate before access
// - Precharge to idle bank is accepted
// - Refresh row internal, one per command
// - Refresh code with clock enable low
// - DLL off in self refresh, on after
// - Mode kept until reload, M8 self-clears
// - M0-M2 choose burst of four or eight
// - Burst wraps inside aligned column block
// - M3 chooses sequential or interleaved order
// - Interleave xors beat, sequential wraps nibble
// - Chip select high ignores new commands
module ddrcm_top
    import ddrcm_pkg::*;
#(
    parameter int ROW_W = 14,
    parameter int COL_W = 10,
    parameter int DQ_W = 16,
    parameter int PL_MAX = 5
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [15:0] addr,
    // Write data pins
    input wire logic [DQ_W-1:0] dq_in,
    input wire logic [DQ_W/8-1:0] dm_in,
    // Array access beats
    output logic beat_valid,
    output logic beat_write,
    output logic [1:0] beat_bank,
    output logic [ROW_W-1:0] beat_row,
    output logic [COL_W-1:0] beat_col,
    output logic [DQ_W-1:0] beat_data,
    output logic [DQ_W/8-1:0] beat_lane_en,
    // Maintenance
    output logic refresh_pulse,
    output logic [ROW_W-1:0] refresh_row,
    output logic self_refresh,
    output logic dll_on,
    // AXI4-Lite slave
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ==========================================================
    // Queued command layout
    localparam int LANES = DQ_W / 8;
    localparam int E_BA = COL_W;
    localparam int E_AP = COL_W + 2;
    localparam int E_WR = COL_W + 3;
    localparam int EW = COL_W + 4;

    // ==========================================================
    // Helpers
    // Clamp latency to queue depth
    function automatic logic [PL_W-1:0] pl_clamp(input logic [PL_W-1:0] v);
        pl_clamp = (v > PL_W'(PL_MAX)) ? PL_W'(PL_MAX) : v;
    endfunction : pl_clamp

    // Beat n column; fixed upper bits wrap the burst
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] s,
        input logic [2:0] n, input logic il);
        logic [2:0] lo;
        lo = il ? (s[2:0] ^ n) : {s[2] ^ n[2], s[1:0] + n[1:0]};
        burst_col = {s[COL_W-1:3], lo};
    endfunction : burst_col

    // ==========================================================
    // State
    logic sref_reg; // Self refresh active
    logic dll_on_reg; // DLL running
    logic [3:0] open_reg; // Row open per bank
    logic [3:0] open_next;
    logic [ROW_W-1:0] row_reg [0:3]; // Open row per bank
    logic [MODE_W-1:0] mode_reg [0:3]; // Mode register set
    logic [ROW_W-1:0] ref_row_reg; // Internal refresh row
    logic ref_pulse_reg;
    logic [PL_W-1:0] pl_reg; // Posted latency from software
    logic [EW-1:0] pipe_reg [0:PL_MAX]; // Posted command queue
    logic [PL_MAX:0] pipe_v_reg;
    logic [EW-1:0] pipe_next [0:PL_MAX];
    logic [PL_MAX:0] pipe_v_next;
    ddrcm_burst_type burst_st_reg;
    ddrcm_burst_type burst_st_next;
    logic [2:0] bcnt_reg; // Beat count within burst
    logic [2:0] bcnt_next;
    logic [COL_W-1:0] bstart_reg; // Start column
    logic [1:0] bbank_reg; // Burst bank
    logic bap_reg; // Auto precharge at end
    logic bvalid_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [1:0] bresp_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [AXI_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic beat_valid_reg;
    logic beat_write_reg;
    logic [1:0] beat_bank_reg;
    logic [ROW_W-1:0] beat_row_reg;
    logic [COL_W-1:0] beat_col_reg;
    logic [DQ_W-1:0] beat_data_reg;
    logic [LANES-1:0] beat_lane_reg;

    // ==========================================================
    // Command decode; cs_n high matches no code
    wire logic [3:0] cmd_code;
    wire logic awake;
    wire logic live;
    wire logic do_mode;
    wire logic do_act;
    wire logic do_pre;
    wire logic do_ref;
    wire logic do_sref;
    wire logic do_rw;
    wire logic sref_next;
    assign cmd_code = {cs_n, ras_n, cas_n, we_n};
    assign awake = !sref_reg;
    assign live = awake && cke;
    assign do_mode = live && (cmd_code == CMD_MODE);
    assign do_act = live && (cmd_code == CMD_ACT);
    assign do_pre = live && (cmd_code == CMD_PRE);
    assign do_ref = live && (cmd_code == CMD_REF);
    assign do_rw = live && (cmd_code == CMD_WR || cmd_code == CMD_RD);
    assign do_sref = awake && !cke && (cmd_code == CMD_REF);
    assign sref_next = do_sref || (sref_reg && !cke);

    // ==========================================================
    // Mode fields in use
    wire logic bl8;
    wire logic intlv;
    wire logic [2:0] blast;
    wire logic [PL_W-1:0] pl_eff;
    assign bl8 = (mode_reg[0][LEN_MSB:0] == BL8_CODE);
    assign intlv = mode_reg[0][BT_BIT];
    assign blast = bl8 ? LAST8 : LAST4;
    assign pl_eff = pl_clamp(pl_reg);

    // ==========================================================
    // Posted queue: enter at latency slot, leave at 0
    wire logic [EW-1:0] new_entry;
    assign new_entry = {cmd_code == CMD_WR, addr[AP_BIT], ba[1:0], addr[COL_W-1:0]};

    // Shift to slot 0, insert new command
    always_comb
    begin
        pipe_next[PL_MAX] = '0;
        pipe_v_next[PL_MAX] = 1'b0;
        for (int i = 0; i < PL_MAX; i++)
        begin
            pipe_next[i] = pipe_reg[i+1];
            pipe_v_next[i] = pipe_v_reg[i+1];
        end
        if (do_rw)
        begin
            pipe_next[pl_eff] = new_entry;
            pipe_v_next[pl_eff] = 1'b1;
        end
    end

    // Queue registers
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pipe_v_reg <= '0;
            for (int i = 0; i <= PL_MAX; i++)
                pipe_reg[i] <= '0;
        end
        else
        begin
            pipe_v_reg <= pipe_v_next;
            for (int i = 0; i <= PL_MAX; i++)
                pipe_reg[i] <= pipe_next[i];
        end
    end

    // ==========================================================
    // Registration; closed bank drops the access
    wire logic [1:0] q_bank;
    wire logic reg_rw;
    wire logic busy;
    wire logic burst_end;
    assign q_bank = pipe_reg[0][E_BA+:2];
    assign reg_rw = pipe_v_reg[0] && open_reg[q_bank];
    assign busy = (burst_st_reg != BST_IDLE);
    assign burst_end = busy && (bcnt_reg == blast);

    // Burst next state; new command restarts
    always_comb
    begin
        burst_st_next = burst_st_reg;
        bcnt_next = busy ? bcnt_reg + 3'h1 : 3'h0;
        case (burst_st_reg)
            BST_IDLE: burst_st_next = BST_IDLE;
            BST_READ, BST_WRITE:
                if (burst_end)
                    burst_st_next = BST_IDLE;
            default: burst_st_next = BST_IDLE;
        endcase
        if (reg_rw)
        begin
            burst_st_next = pipe_reg[0][E_WR] ? BST_WRITE : BST_READ;
            bcnt_next = 3'h0;
        end
    end

    // Burst registers
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            burst_st_reg <= BST_IDLE;
            bcnt_reg <= 3'h0;
            bstart_reg <= '0;
            bbank_reg <= 2'h0;
            bap_reg <= 1'b0;
        end
        else
        begin
            burst_st_reg <= burst_st_next;
            bcnt_reg <= bcnt_next;
            if (reg_rw)
            begin
                bstart_reg <= pipe_reg[0][COL_W-1:0];
                bbank_reg <= q_bank;
                bap_reg <= pipe_reg[0][E_AP];
            end
        end
    end

    // ==========================================================
    // Bank state; others usable while one closes
    always_comb
    begin
        open_next = open_reg;
        if (burst_end && bap_reg)
            open_next[bbank_reg] = 1'b0;
        if (do_pre)
        begin
            // Precharge of an idle bank is harmless
            if (addr[AP_BIT])
                open_next = '0;
            else
                open_next[ba[1:0]] = 1'b0;
        end
        if (do_act)
            open_next[ba[1:0]] = 1'b1;
    end

    // Bank and row registers
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            open_reg <= '0;
            for (int i = 0; i < 4; i++)
                row_reg[i] <= '0;
        end
        else
        begin
            open_reg <= open_next;
            if (do_act)
                row_reg[ba[1:0]] <= addr[ROW_W-1:0];
        end
    end

    // ==========================================================
    // Beat outputs; write data taken in beat cycle
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            beat_valid_reg <= 1'b0;
            beat_write_reg <= 1'b0;
            beat_bank_reg <= 2'h0;
            beat_row_reg <= '0;
            beat_col_reg <= '0;
            beat_data_reg <= '0;
            beat_lane_reg <= '0;
        end
        else
        begin
            beat_valid_reg <= busy;
            beat_write_reg <= (burst_st_reg == BST_WRITE);
            beat_bank_reg <= bbank_reg;
            beat_row_reg <= row_reg[bbank_reg];
            beat_col_reg <= burst_col(bstart_reg, bcnt_reg, intlv);
            beat_data_reg <= dq_in;
            // Masked lanes are never enabled
            beat_lane_reg <= (burst_st_reg == BST_WRITE) ? ~dm_in : '0;
        end
    end

    // ==========================================================
    // Mode registers, refresh counter, self refresh and DLL
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                mode_reg[i] <= '0;
            ref_row_reg <= '0;
            ref_pulse_reg <= 1'b0;
            sref_reg <= 1'b0;
            dll_on_reg <= 1'b1;
        end
        else
        begin
            // New load beats M8 self-clear
            if (do_mode)
                mode_reg[ba[1:0]] <= addr[MODE_W-1:0];
            else if (mode_reg[0][DLLRST_BIT])
                mode_reg[0][DLLRST_BIT] <= 1'b0;
            // Row from counter, address ignored
            if (do_ref || do_sref)
                ref_row_reg <= ref_row_reg + ROW_W'(1);
            ref_pulse_reg <= do_ref || do_sref;
            sref_reg <= sref_next;
            dll_on_reg <= !sref_next;
        end
    end

    // ==========================================================
    // AXI4-Lite slave, one write and one read
    wire logic wr_fire;
    wire logic wr_ctrl;
    wire logic rd_fire;
    wire logic [31:0] status_word;
    wire logic [31:0] rd_word;
    wire logic rd_hit;
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_fire = aw_hold_reg && w_hold_reg;
    assign wr_ctrl = wr_fire && (awaddr_reg == OFS_CTRL) && wstrb_reg[0];
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign status_word = 32'({busy, dll_on_reg, sref_reg, open_reg});
    assign rd_hit = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_STATUS)
        || (s_axi_araddr == OFS_MODE) || (s_axi_araddr == OFS_REFROW);
    assign rd_word = (s_axi_araddr == OFS_CTRL) ? 32'(pl_reg)
        : (s_axi_araddr == OFS_STATUS) ? status_word
        : (s_axi_araddr == OFS_MODE) ? 32'(mode_reg[0])
        : (s_axi_araddr == OFS_REFROW) ? 32'(ref_row_reg) : 32'h0000_0000;

    // Write path: halves taken in either order
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            pl_reg <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                // Only the control word is writable
                bresp_reg <= (awaddr_reg == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
            if (wr_ctrl)
                pl_reg <= wdata_reg[PL_W-1:0];
        end
    end

    // Read path: answer a cycle after address
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // ==========================================================
    // Output drive
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign beat_valid = beat_valid_reg;
    assign beat_write = beat_write_reg;
    assign beat_bank = beat_bank_reg;
    assign beat_row = beat_row_reg;
    assign beat_col = beat_col_reg;
    assign beat_data = beat_data_reg;
    assign beat_lane_en = beat_lane_reg;
    assign refresh_pulse = ref_pulse_reg;
    assign refresh_row = ref_row_reg;
    assign self_refresh = sref_reg;
    assign dll_on = dll_on_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_nop_keeps_banks: assert property (
        (cs_n || cmd_code == CMD_NOP) && !(burst_end && bap_reg)
        |=> open_reg == $past(open_reg)) else $error("banks moved");
    a_mode_load_bank: assert property (
        do_mode |=> mode_reg[$past(ba[1:0])] == $past(addr[MODE_W-1:0]))
        else $error("mode load lost");
    a_dllrst_clears: assert property (
        mode_reg[0][DLLRST_BIT] && !do_mode |=> !mode_reg[0][DLLRST_BIT])
        else $error("M8 stuck");
    a_act_opens: assert property (
        do_act |=> open_reg[$past(ba[1:0])]) else $error("bank not opened");
    a_pre_all: assert property (
        do_pre && addr[AP_BIT] |=> open_reg == 4'h0) else $error("precharge all failed");
    a_posted_delay: assert property (
        do_rw && pl_eff == 3'h2 && !wr_ctrl |-> ##3 pipe_v_reg[0])
        else $error("latency wrong");
    a_closed_dropped: assert property (
        pipe_v_reg[0] && !reg_rw && !busy |=> !busy) else $error("idle bank ran");
    a_burst_eight: assert property (
        reg_rw && bl8 |=> busy [*8]) else $error("burst too short");
    a_mask_lane: assert property (
        beat_valid && beat_write |-> beat_lane_en == ~$past(dm_in))
        else $error("mask not honoured");
    a_wrap_block: assert property (
        busy |=> beat_col[COL_W-1:3] == $past(bstart_reg[COL_W-1:3])
        && ($past(bl8) || beat_col[2] == $past(bstart_reg[2])))
        else $error("burst left block");
    a_interleave: assert property (
        busy && intlv |=> beat_col[2:0] == ($past(bstart_reg[2:0]) ^ $past(bcnt_reg)))
        else $error("bad interleave");
    a_refresh_step: assert property (
        do_ref |=> refresh_row == $past(refresh_row) + ROW_W'(1) && refresh_pulse)
        else $error("refresh row stuck");
    a_sref_dll: assert property (
        do_sref |=> self_refresh && !dll_on) else $error("DLL on in self refresh");

    c_write_burst: cover property (reg_rw && pipe_reg[0][E_WR] ##1 busy [*4]);
    c_read_autopre: cover property (burst_end && bap_reg && burst_st_reg == BST_READ);
    c_self_refresh: cover property (do_sref ##[1:20] !self_refresh);
    c_mode_load: cover property (do_mode && addr[DLLRST_BIT]);

endmodule : ddrcm_top

`default_nettype wire

// ===== test/ddrcm_ctrl_model.sv
// Controller model: command, address and write data pins.
// Assumes cmd is called from one process after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ddrcm_ctrl_model
    import ddrcm_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Command and data pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic [15:0] addr,
    output logic [15:0] dq_in,
    output logic [1:0] dm_in
);
    // ==========================================================
    // Idle pins: clock enabled, nop
    initial
    begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
        {ba, addr, dq_in, dm_in} = '0;
    end
    // Random data and mask each cycle
    always @(posedge sys_clk)
        {dq_in, dm_in} <= 18'($urandom);
    // One command for one edge, then nop
    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                       input logic [15:0] a, input logic k);
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= {1'h0, b};
        addr <= (c == CMD_MODE) ? {3'h0, a[12:0]} : a;
        cke <= k;
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= CMD_NOP;
        // Scramble stale address
        addr <= ~addr;
    endtask : cmd
endmodule : ddrcm_ctrl_model
`default_nettype wire

// ===== test/ddrcm_top_bench.sv
// Bench: pin-level model of beats, refresh and registers.
// Assumes ddrcm_ctrl_model drives every command pin.
`timescale 1ns/1ps
`default_nettype none
module ddrcm_top_bench;
    import ddrcm_pkg::*;
    // Beat expected by the model
    typedef struct {int due; logic w; logic [1:0] b; logic [13:0] r; logic [9:0] c;} ddrcm_beat_type;
    logic sys_clk = 0;
    logic sys_rst = 1;
    logic cke, cs_n, ras_n, cas_n, we_n, beat_valid, beat_write, refresh_pulse, self_refresh, dll_on;
    logic [2:0] ba;
    logic [15:0] addr, dq_in, beat_data, pdq;
    logic [1:0] dm_in, beat_bank, beat_lane_en, pdm, s_axi_bresp, s_axi_rresp;
    logic [13:0] beat_row, refresh_row, rrow = 0;
    logic [13:0] row [4];
    logic [9:0] beat_col;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, op = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rp = 0, sr = 0;
    logic [12:0] mr0 = 0;
    int cyc, pl_set, n_errors, compares;
    ddrcm_beat_type q [$];
    ddrcm_beat_type bt;
    wire [26:0] beat_seen = {beat_write, beat_bank, beat_row, beat_col};
    ddrcm_top dut (.*);
    ddrcm_ctrl_model ctl (.*);
    // ==========================================================
    // Clock, 4 ns
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Column of beat n
    function automatic logic [9:0] colf(logic [9:0] s, int n, logic il, logic b8);
        logic [2:0] c;
        c = il ? s[2:0] ^ n[2:0] : {s[2] ^ n[2], s[1:0] + n[1:0]};
        if (!b8)
            c[2] = s[2];
        return {s[9:3], c};
    endfunction : colf
    function automatic logic [31:0] status_exp();
        return {26'h0, !sr, sr, op};
    endfunction : status_exp
    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // AXI write: hold each channel until taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int t = 0; t < 64; t++)
        begin
            @(posedge sys_clk);
            if (s_axi_bvalid)
                break;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        chk("bresp", {30'h1, er}, {30'(s_axi_bvalid), s_axi_bresp});
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int t = 0; t < 64; t++)
        begin
            @(posedge sys_clk);
            if (s_axi_rvalid)
                break;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h1, er}, {30'(s_axi_rvalid), s_axi_rresp});
    endtask : axr
    // ==========================================================
    // Pin model: check outputs, then take command
    always @(posedge sys_clk)
    begin
        if (!sys_rst)
        begin
            cyc++;
            chk("refresh", {rp, 17'h0, rrow}, {refresh_pulse, 17'h0, refresh_row});
            chk("self_refresh", {sr, !sr}, {self_refresh, dll_on});
            if (q.size() > 0 && q[0].due == cyc)
            begin
                bt = q.pop_front();
                chk("beat", 32'({bt.w, bt.b, bt.r, bt.c}), 32'(beat_seen));
                chk("lanes", {pdq, 14'h0, bt.w ? ~pdm : 2'h0}, {beat_data, 14'h0, beat_lane_en});
                chk("beat_valid", 1, {beat_lane_en != 0 && !bt.w, beat_valid});
            end
            else
                chk("beat_valid", 0, 32'(beat_valid));
            rp = 1'h0;
            pdq = dq_in;
            pdm = dm_in;
            if (sr)
                sr = !cke;
            else if (!cs_n && (cke || {ras_n, cas_n, we_n} == 3'h1))
                case ({ras_n, cas_n, we_n})
                    3'h0: if (ba[1:0] == 2'h0) mr0 = addr[12:0] & 13'h1EFF;
                    3'h1:
                    begin
                        rp = 1'h1;
                        rrow++;
                        sr = !cke;
                    end
                    3'h2: if (addr[10]) op = 4'h0; else op[ba[1:0]] = 1'h0;
                    3'h3:
                    begin
                        op[ba[1:0]] = 1'h1;
                        row[ba[1:0]] = addr[13:0];
                    end
                    3'h4, 3'h5:
                    begin
                        for (int n = 0; n < ((mr0[2:0] == BL8_CODE) ? 8 : 4) && op[ba[1:0]]; n++)
                            q.push_back('{cyc + pl_set + 3 + n, !we_n, ba[1:0], row[ba[1:0]],
                                colf(addr[9:0], n, mr0[3], mr0[2:0] == BL8_CODE)});
                        if (addr[10])
                            op[ba[1:0]] = 1'h0;
                    end
                    default: ;
                endcase
        end
    end
    // ==========================================================
    // Test sequence
    initial
    begin
        void'($urandom(11));
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'h0;
        for (int m = 0; m < 4; m++)
        begin
            pl_set = $urandom % 6;
            axw(OFS_CTRL, pl_set, RESP_OKAY);
            axr(OFS_CTRL, pl_set, RESP_OKAY);
            ctl.cmd(CMD_PRE, 2'h0, 16'h0400, 1'h1);
            ctl.cmd(CMD_MODE, 2'h0, 16'({m[1], m[0] ? BL8_CODE : 3'h2}), 1'h1);
            for (int s = 0; s < 8; s++)
            begin
                ctl.cmd(CMD_PRE, s[1:0], 16'h0000, 1'h1);
                ctl.cmd(CMD_ACT, s[1:0], 16'($urandom), 1'h1);
                ctl.cmd(s[0] ? CMD_RD : CMD_WR, s[1:0], {5'h0, s[2], 7'($urandom), s[2:0]}, 1'h1);
                repeat (pl_set + 12) @(posedge sys_clk);
            end
        end
        $display("done: burst orders");
        ctl.cmd(CMD_PRE, 2'h0, 16'h0400, 1'h1);
        ctl.cmd(4'hB, 2'h2, 16'h0000, 1'h1);
        axr(OFS_STATUS, status_exp(), RESP_OKAY);
        ctl.cmd(CMD_RD, 2'h2, 16'h0000, 1'h1);
        repeat (3) ctl.cmd(CMD_REF, 2'h0, 16'($urandom), 1'h1);
        ctl.cmd(CMD_REF, 2'h0, 16'h0000, 1'h0);
        ctl.cmd(CMD_ACT, 2'h0, 16'h0000, 1'h0);
        axr(OFS_STATUS, status_exp(), RESP_OKAY);
        ctl.cmd(CMD_NOP, 2'h0, 16'h0000, 1'h1);
        ctl.cmd(CMD_RD, 2'h0, 16'h0000, 1'h1);
        repeat (pl_set + 12) @(posedge sys_clk);
        axr(OFS_STATUS, status_exp(), RESP_OKAY);
        $display("done: refresh and deselect");
        ctl.cmd(CMD_MODE, 2'h0, 16'h0103, 1'h1);
        ctl.cmd(CMD_MODE, 2'h1, 16'h000A, 1'h1);
        axr(OFS_MODE, 32'(mr0), RESP_OKAY);
        axr(8'h10, 32'h00000000, RESP_SLVERR);
        axw(OFS_STATUS, 32'h0000000F, RESP_SLVERR);
        axr(OFS_CTRL, pl_set, RESP_OKAY);
        chk("beats left", 0, 32'(q.size()));
        $display("done: mode and registers");
        tally_and_finish();
    end
    // Watchdog: 20000 cycles
    initial
    begin
        #80000;
        n_errors++;
        tally_and_finish();
    end
endmodule : ddrcm_top_bench
`default_nettype wire
